// *** hdl/flash_readout_host.v ***
// host controller that issues command writes and read cycles to the flash
// assumes the flash pins are synchronous enough to sample on ref_clk; one request at a time
`timescale 1ns/1ps
`default_nettype none
`include "flash_readout_regs.vh"
module flash_readout_host #(
    parameter ADDR_W = 21
) (
    input  wire              ref_clk,
    input  wire              rst_b,
    // user side
    input  wire              req_valid,
    output wire              req_ready,
    input  wire [2:0]        req_op,
    input  wire [ADDR_W-1:0] req_addr,
    input  wire [7:0]        req_cmd,
    input  wire              byte_mode,
    output reg               resp_valid,
    output reg  [15:0]       resp_data,
    output reg               resp_ok,
    output reg  [1:0]        cur_mode,
    // flash pins
    output reg  [ADDR_W-1:0] flash_addr,
    output reg               ce_n,
    output reg               oe_n,
    output reg               we_n,
    output reg               powerdown_reset_n,
    output reg               byte_n,
    output reg  [15:0]       dq_out,
    output reg               dq_oe_n,
    input  wire [15:0]       dq_in
);
    // ****************************************
    // operations and read modes
    // ****************************************
    localparam OP_CMD      = 3'd0;  // write req_cmd
    localparam OP_READ     = 3'd1;  // read at req_addr in current mode
    localparam OP_BLKSTAT  = 3'd2;  // ready-checked block status read
    localparam OP_POWERUP  = 3'd3;  // release power-down reset

    localparam MODE_ARRAY  = 2'd0;
    localparam MODE_ID     = 2'd1;
    localparam MODE_STATUS = 2'd2;
    localparam MODE_QUERY  = 2'd3;

    localparam S_IDLE   = 3'd0;
    localparam S_WRITE  = 3'd1;
    localparam S_READ   = 3'd2;
    localparam S_GAP    = 3'd3;
    localparam S_STATW  = 3'd4;
    localparam S_STATR  = 3'd5;
    localparam S_BLKW   = 3'd6;
    localparam S_DONE   = 3'd7;

    localparam integer STROBE_CYC  = `T_STROBE_CYC;
    localparam integer RECOVER_CYC = `T_RECOVER_CYC;
    localparam [3:0]   STROBE      = STROBE_CYC[3:0];
    localparam [3:0]   RECOVER     = RECOVER_CYC[3:0];

    reg  [2:0]        state;
    reg  [ADDR_W-1:0] addr;
    reg  [7:0]        cmd;
    reg  [2:0]        after_gap;
    reg               tstart;
    reg  [3:0]        tlen;
    wire              tdone;

    flash_cycle_timer #(.WIDTH(4)) u_timer (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .start   (tstart),
        .length  (tlen),
        .done    (tdone)
    );

    assign req_ready = (state == S_IDLE);

    // query byte mode: bit 0 is don't-care, so the host doubles the word offset
    function [ADDR_W-1:0] query_addr;
        input [ADDR_W-1:0] a;
        input              bm;
        begin
            query_addr = bm ? {a[ADDR_W-2:0], 1'b0} : a;
        end
    endfunction

    // ****************************************
    // bus sequencer
    // ****************************************
    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            state             <= S_IDLE;
            addr              <= {ADDR_W{1'b0}};
            cmd               <= 8'h00;
            after_gap         <= S_DONE;
            tstart            <= 1'b0;
            tlen              <= 4'h0;
            resp_valid        <= 1'b0;
            resp_data         <= 16'h0000;
            resp_ok           <= 1'b0;
            cur_mode          <= MODE_ARRAY;
            flash_addr        <= {ADDR_W{1'b0}};
            ce_n              <= 1'b1;
            oe_n              <= 1'b1;
            we_n              <= 1'b1;
            powerdown_reset_n <= 1'b0;
            byte_n            <= 1'b1;
            dq_out            <= 16'h0000;
            dq_oe_n           <= 1'b1;
        end else begin
            tstart     <= 1'b0;
            resp_valid <= 1'b0;
            byte_n     <= ~byte_mode;
            case (state)
                S_IDLE: begin
                    if (req_valid) begin
                        addr <= req_addr;
                        cmd  <= req_cmd;
                        case (req_op)
                            OP_POWERUP: begin
                                // device comes back in array read mode
                                powerdown_reset_n <= 1'b1;
                                cur_mode          <= MODE_ARRAY;
                                resp_ok           <= 1'b1;
                                state             <= S_DONE;
                            end
                            OP_CMD: begin
                                flash_addr <= req_addr;
                                dq_out     <= {8'h00, req_cmd};
                                dq_oe_n    <= 1'b0;
                                ce_n       <= 1'b0;
                                we_n       <= 1'b0;
                                tstart     <= 1'b1;
                                tlen       <= STROBE;
                                state      <= S_WRITE;
                            end
                            OP_BLKSTAT: begin
                                // read-status is legal even mid-operation
                                dq_out  <= {8'h00, `CMD_READ_STATUS};
                                dq_oe_n <= 1'b0;
                                ce_n    <= 1'b0;
                                we_n    <= 1'b0;
                                tstart  <= 1'b1;
                                tlen    <= STROBE;
                                state   <= S_STATW;
                            end
                            default: begin
                                flash_addr <= (cur_mode == MODE_QUERY) ?
                                              query_addr(req_addr, byte_mode) : req_addr;
                                ce_n       <= 1'b0;
                                oe_n       <= 1'b0;
                                tstart     <= 1'b1;
                                tlen       <= STROBE;
                                state      <= S_READ;
                            end
                        endcase
                    end
                end
                S_WRITE, S_STATW, S_BLKW: begin
                    if (tdone) begin
                        ce_n    <= 1'b1;
                        we_n    <= 1'b1;
                        dq_oe_n <= 1'b1;
                        tstart  <= 1'b1;
                        tlen    <= RECOVER;
                        state   <= S_GAP;
                        if (state == S_WRITE) begin
                            after_gap <= S_DONE;
                            resp_ok   <= 1'b1;
                            case (cmd)
                                `CMD_READ_ID:     cur_mode <= MODE_ID;
                                `CMD_READ_STATUS: cur_mode <= MODE_STATUS;
                                `CMD_MULTI_WRITE: cur_mode <= MODE_STATUS;
                                `CMD_QUERY:       cur_mode <= MODE_QUERY;
                                `CMD_CLEAR_STATUS: cur_mode <= cur_mode;
                                default:          cur_mode <= MODE_ARRAY;
                            endcase
                        end else if (state == S_STATW) begin
                            cur_mode  <= MODE_STATUS;
                            after_gap <= S_STATR;
                        end else begin
                            cur_mode  <= MODE_QUERY;
                            after_gap <= S_READ;
                        end
                    end
                end
                S_GAP: begin
                    // strobes stay high a full recovery so the next read sees fresh status
                    if (tdone) begin
                        if (after_gap == S_DONE) begin
                            state <= S_DONE;
                        end else if (after_gap == S_STATR) begin
                            ce_n   <= 1'b0;
                            oe_n   <= 1'b0;
                            tstart <= 1'b1;
                            tlen   <= STROBE;
                            state  <= S_STATR;
                        end else begin
                            flash_addr <= query_addr(addr + `QRY_BLOCK_OFS, byte_mode);
                            ce_n       <= 1'b0;
                            oe_n       <= 1'b0;
                            tstart     <= 1'b1;
                            tlen       <= STROBE;
                            state      <= S_READ;
                        end
                    end
                end
                S_STATR: begin
                    if (tdone) begin
                        ce_n <= 1'b1;
                        oe_n <= 1'b1;
                        if (dq_in[`SR_READY_BIT]) begin
                            dq_out  <= {8'h00, `CMD_QUERY};
                            dq_oe_n <= 1'b0;
                            ce_n    <= 1'b0;
                            we_n    <= 1'b0;
                            tstart  <= 1'b1;
                            tlen    <= STROBE;
                            state   <= S_BLKW;
                        end else begin
                            // busy: block status would be stale, report refusal
                            resp_data <= {8'h00, dq_in[7:0]};
                            resp_ok   <= 1'b0;
                            tstart    <= 1'b1;
                            tlen      <= RECOVER;
                            after_gap <= S_DONE;
                            state     <= S_GAP;
                        end
                    end
                end
                S_READ: begin
                    if (tdone) begin
                        ce_n    <= 1'b1;
                        oe_n    <= 1'b1;
                        resp_ok <= powerdown_reset_n;
                        if (cur_mode == MODE_QUERY) begin
                            // only the low byte carries query data
                            resp_data <= {8'h00, dq_in[7:0]};
                        end else if (byte_mode) begin
                            resp_data <= {8'h00, dq_in[7:0]};
                        end else begin
                            resp_data <= dq_in;
                        end
                        tstart    <= 1'b1;
                        tlen      <= RECOVER;
                        after_gap <= S_DONE;
                        state     <= S_GAP;
                    end
                end
                S_DONE: begin
                    resp_valid <= 1'b1;
                    state      <= S_IDLE;
                end
                default: begin
                    state <= S_IDLE;
                end
            endcase
        end
    end
endmodule
`default_nettype wire

// *** hdl/flash_readout_regs.vh ***
// constants for the host-side controller of a parallel flash readout interface
// assumes the flash is asynchronous and its pins are wired straight to the controller
// Notes on behaviour
// - identifier mode lasts until another command; clear status (50H) keeps the current mode here
// - block status trusted only when ready set
// - status latched on strobe fall; raise between
// - multi-word write command selects extended status
`ifndef FLASH_READOUT_REGS_VH
`define FLASH_READOUT_REGS_VH

// ****************************************
// command bytes
// ****************************************
`define CMD_READ_ARRAY     8'hFF
`define CMD_READ_ID        8'h90
`define CMD_READ_STATUS    8'h70
`define CMD_CLEAR_STATUS   8'h50
`define CMD_QUERY          8'h98
`define CMD_MULTI_WRITE    8'hE8

// ****************************************
// identifier and query offsets
// ****************************************
`define ID_MANUF_OFS       16'h0000
`define ID_DEVICE_OFS      16'h0003
`define ID_BLOCK_OFS       16'h0004
`define QRY_BLOCK_OFS      16'h0002
`define QRY_STRING_OFS     16'h0010
`define QRY_STRING_LEN     5'h03
`define QRY_ALT_OFS        16'h0017

// ****************************************
// status and block status fields
// ****************************************
`define SR_READY_BIT       7
`define SR_ERASE_ERR_BIT   5
`define SR_PROG_ERR_BIT    4
`define SR_SUPPLY_BIT      3
`define SR_LOCK_VIOL_BIT   1
`define BSR_LOCK_BIT       0
`define BSR_ERASE_BIT      1

// ****************************************
// bus timing, ns and cycles at 25 MHz
// ****************************************
`define CLK_PERIOD_NS      40
`define T_STROBE_NS        120
`define T_RECOVER_NS       40
`define T_STROBE_CYC       ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RECOVER_CYC      ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`endif

// *** hdl/flash_cycle_timer.v ***
// cycle counter that times one strobe phase of a flash bus cycle
// assumes start is a one-cycle pulse from the sequencer
`timescale 1ns/1ps
`default_nettype none
module flash_cycle_timer #(
    parameter WIDTH = 4
) (
    input  wire             ref_clk,
    input  wire             rst_b,
    input  wire             start,
    input  wire [WIDTH-1:0] length,
    output wire             done
);
    reg [WIDTH-1:0] count;

    always @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) begin
            count <= {WIDTH{1'b0}};
        end else if (start) begin
            count <= length;
        end else if (count != {WIDTH{1'b0}}) begin
            count <= count - {{(WIDTH-1){1'b0}}, 1'b1};
        end
    end

    assign done = (count == {{(WIDTH-1){1'b0}}, 1'b1});
endmodule
`default_nettype wire

// *** sim/flash_readout_chk.sv ***
// port checks for the flash readout host
// assumes bind into flash_readout_host
`timescale 1ns/1ps
`default_nettype none
module flash_readout_chk (
    input wire logic        ref_clk,
    input wire logic        rst_b,
    input wire logic        req_valid,
    input wire logic        req_ready,
    input wire logic [2:0]  req_op,
    input wire logic        resp_valid,
    input wire logic [15:0] resp_data,
    input wire logic        resp_ok,
    input wire logic [1:0]  cur_mode,
    input wire logic        ce_n,
    input wire logic        oe_n,
    input wire logic        we_n,
    input wire logic        powerdown_reset_n,
    input wire logic [15:0] dq_out,
    input wire logic        dq_oe_n
);
    logic [2:0] last_op;
    always_ff @(posedge ref_clk or negedge rst_b) begin
        if (!rst_b) last_op <= 3'h0;
        else if (req_valid && req_ready) last_op <= req_op;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_b);
    // only plain command requests, op 2 walks through modes internally
    sequence cmd_s(logic [7:0] c);
        $fell(we_n) && dq_out[7:0] == c && last_op == 3'h0;
    endsequence
    AST_RESP_ONE: assert property (resp_valid |=> !resp_valid) else $error("resp pulse long");
    AST_TAKE: assert property (req_valid && req_ready |=> !req_ready) else $error("ready stayed");
    AST_RESP_BOUND: assert property (req_valid && req_ready && req_op != 3'h2
        |-> ##[1:12] resp_valid) else $error("no answer");
    // the timer loads one edge after its start pulse, so a strobe spans four edges
    AST_WE_WIDTH: assert property ($fell(we_n) |-> !we_n [*4] ##1 we_n)
        else $error("write strobe width");
    AST_OE_WIDTH: assert property ($fell(oe_n) |-> !oe_n [*4] ##1 oe_n)
        else $error("read strobe width");
    AST_WR_DRIVE: assert property (!we_n |-> !dq_oe_n && !ce_n && oe_n)
        else $error("write not driven");
    AST_RD_FREE: assert property (!oe_n |-> dq_oe_n && we_n) else $error("bus driven in read");
    AST_PD_NOK: assert property (resp_valid && !powerdown_reset_n |-> !resp_ok)
        else $error("ok in power-down");
    AST_ID_MODE: assert property (cmd_s(8'h90) |-> ##[1:12] cur_mode == 2'h1)
        else $error("no id mode");
    AST_ST_MODE: assert property (cmd_s(8'h70) |-> ##[1:12] cur_mode == 2'h2)
        else $error("no status mode");
    AST_QRY_MODE: assert property (cmd_s(8'h98) |-> ##[1:12] cur_mode == 2'h3)
        else $error("no query mode");
    AST_CLR_KEEP: assert property (cmd_s(8'h50) |-> ##1 $stable(cur_mode) [*5])
        else $error("clear changed mode");
    AST_QRY_HI: assert property (resp_valid && last_op == 3'h1 && cur_mode == 2'h3
        |-> resp_data[15:8] == 8'h00) else $error("query high byte");
endmodule
bind flash_readout_host flash_readout_chk flash_readout_chk_inst (.ref_clk, .rst_b,
    .req_valid, .req_ready, .req_op, .resp_valid, .resp_data, .resp_ok, .cur_mode,
    .ce_n, .oe_n, .we_n, .powerdown_reset_n, .dq_out, .dq_oe_n);
`default_nettype wire

// *** sim/flash_readout_model.sv ***
// behavioural flash device, readout modes only
// assumes strobes from the host; busy and err_set come from the bench
`timescale 1ns/1ps
`default_nettype none
module flash_readout_model #(
    parameter [7:0]  MANUF  = 8'h5A, // arbitrary value
    parameter [7:0]  DEVICE = 8'h3C, // arbitrary value
    parameter [15:0] SET_ID = 16'h0001,
    parameter [15:0] EXT_AD = 16'h0031,
    parameter [7:0]  EXT_SR = 8'h80
) (
    input  wire logic [20:0] flash_addr,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        powerdown_reset_n,
    input  wire logic        byte_n,
    input  wire logic [15:0] dq_out,
    input  wire logic        busy,
    input  wire logic        err_set,
    output wire logic [15:0] dq_in
);
    logic [2:0]  mode;
    logic [3:0]  flags = 4'h0;
    logic [7:0]  sr_lat, q;
    logic [15:0] val;
    wire         wstb = we_n | ce_n;
    wire         rstb = oe_n | ce_n;
    wire  [4:0]  blk = flash_addr[20:16];
    wire  [15:0] low = flash_addr[15:0];
    wire  [15:0] ofs = byte_n ? low : {1'b0, low[15:1]};
    wire  [7:0]  bsr = {6'h00, blk[1], blk[0]};
    wire  [7:0]  sr_now = {~busy, 1'b0, flags[3:1], 1'b0, flags[0], 1'b0};
    always @(posedge wstb or negedge powerdown_reset_n) begin
        if (!powerdown_reset_n) mode <= 3'h0;
        else case (dq_out[7:0])
            8'hFF: mode <= 3'h0;
            8'h90: mode <= 3'h1;
            8'h70: mode <= 3'h2;
            8'h98: mode <= 3'h3;
            8'hE8: mode <= 3'h4;
            default: mode <= mode;
        endcase
    end
    always @(posedge wstb or posedge err_set) begin
        if (err_set) flags <= 4'hF;
        else if (dq_out[7:0] == 8'h50 && !busy) flags <= 4'h0;
    end
    always @(negedge rstb) sr_lat <= sr_now;
    always @* begin
        case (ofs)
            16'h0002: q = bsr;
            16'h0010: q = 8'h51;
            16'h0011: q = 8'h52;
            16'h0012: q = 8'h59;
            16'h0013: q = SET_ID[7:0];
            16'h0014: q = SET_ID[15:8];
            16'h0015: q = EXT_AD[7:0];
            16'h0016: q = EXT_AD[15:8];
            default: q = 8'h00;
        endcase
        case (mode)
            3'h1: val = {8'h00, low == 16'h0 ? MANUF : low == 16'h3 ? DEVICE
                : (low == 16'h4 || low == 16'h5) ? bsr : 8'h00};
            3'h2: val = {8'h00, sr_lat};
            3'h3: val = {8'h00, q};
            3'h4: val = {8'h00, EXT_SR};
            default: val = low ^ 16'h5A5A;
        endcase
    end
    // released bus shows the inverse so a stale sample cannot pass
    assign dq_in = (rstb || !powerdown_reset_n) ? ~val
        : (mode == 3'h3 && !byte_n) ? {8'hzz, val[7:0]} : val;
endmodule
`default_nettype wire

// *** sim/test_flash_readout_host.sv ***
// random and corner tests of the flash readout host
// assumes the behavioural flash model and the bound checker
`timescale 1ns/1ps
`default_nettype none
module test_flash_readout_host;
    localparam [7:0]  MANUF = 8'hA7; // arbitrary value
    localparam [7:0]  DEVICE = 8'h4E; // arbitrary value
    localparam [15:0] SET_ID = 16'h0001;
    localparam [15:0] EXT_AD = 16'h0031;
    localparam [7:0]  EXT_SR = 8'h80;
    logic        ref_clk, rst_b, req_valid, byte_mode, busy, err_set;
    logic        req_ready, resp_valid, resp_ok, ce_n, oe_n, we_n;
    logic        powerdown_reset_n, byte_n, dq_oe_n;
    logic [2:0]  req_op;
    logic [1:0]  cur_mode;
    logic [7:0]  req_cmd;
    logic [20:0] req_addr, flash_addr, a;
    logic [15:0] resp_data, dq_out, dq_in;
    logic [4:0]  b;
    integer      bad_count, n_compared, cycles, i;
    flash_readout_host #(.ADDR_W(21)) flash_readout_host_inst (.ref_clk, .rst_b,
        .req_valid, .req_ready, .req_op, .req_addr, .req_cmd, .byte_mode, .resp_valid,
        .resp_data, .resp_ok, .cur_mode, .flash_addr, .ce_n, .oe_n, .we_n,
        .powerdown_reset_n, .byte_n, .dq_out, .dq_oe_n, .dq_in);
    flash_readout_model #(.MANUF(MANUF), .DEVICE(DEVICE), .SET_ID(SET_ID), .EXT_AD(EXT_AD),
        .EXT_SR(EXT_SR)) flash_readout_model_inst (.flash_addr, .ce_n, .oe_n, .we_n,
        .powerdown_reset_n, .byte_n, .dq_out, .busy, .err_set, .dq_in);
    function automatic logic [15:0] exp_sr(input logic bz, input logic e);
        return {8'h00, ~bz, 1'b0, e, e, e, 1'b0, e, 1'b0};
    endfunction
    function automatic logic [7:0] exp_q(input integer o);
        case (o)
            16'h10: return 8'h51;
            16'h11: return 8'h52;
            16'h12: return 8'h59;
            16'h13: return SET_ID[7:0];
            16'h14: return SET_ID[15:8];
            16'h15: return EXT_AD[7:0];
            16'h16: return EXT_AD[15:8];
            default: return 8'h00;
        endcase
    endfunction
    task automatic check_data(input string what, input logic [15:0] e, input logic [15:0] g);
        n_compared++;
        if (g !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic check_flag(input string what, input logic e, input logic g);
        check_data(what, {15'h0000, e}, {15'h0000, g});
    endtask
    task automatic report_and_stop;
        $display("compared %0d mismatched %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // left 2 ns after a rising edge; entered 2 ns after one, or 4 ns after it following the err_set pulse
    task automatic run(input logic [2:0] op, input logic [20:0] ad, input logic [7:0] c);
        integer n;
        req_op = op;
        req_addr = ad;
        req_cmd = c;
        req_valid = 1'b1;
        n = 0;
        while (req_ready !== 1'b1 && n < 40) begin
            @(posedge ref_clk);
            #2 n++;
        end
        @(posedge ref_clk);
        #2 req_valid = 1'b0;
        while (resp_valid !== 1'b1 && n < 80) begin
            @(posedge ref_clk);
            #2 n++;
        end
        if (n >= 80) check_flag("answer", 1'b1, 1'b0);
    endtask
    task automatic rd(input logic [20:0] ad);
        run(3'h1, ad, 8'h00);
    endtask
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        cycles = 0;
        forever begin
            @(posedge ref_clk);
            cycles++;
            if (cycles == 5000) begin
                bad_count++;
                report_and_stop;
            end
        end
    end
    initial begin
        {rst_b, req_valid, byte_mode, busy, err_set, req_op, req_cmd, req_addr} = '0;
        bad_count = 0;
        n_compared = 0;
        void'($urandom(32'h3532));
        repeat (4) @(posedge ref_clk);
        #2 rst_b = 1'b1;
        rd(21'h00000);
        check_flag("ok in power-down", 1'b0, resp_ok);
        run(3'h3, 21'h00000, 8'h00);
        for (i = 0; i < 4; i++) begin
            a = 21'($urandom);
            rd(a);
            check_data("array", a[15:0] ^ 16'h5A5A, resp_data);
        end
        run(3'h0, 21'h00000, 8'h90);
        for (i = 0; i < 6; i++) begin
            b = 5'($urandom);
            rd(21'h00000);
            check_data("manufacturer", {8'h00, MANUF}, resp_data);
            rd(21'h00003);
            check_data("device", {8'h00, DEVICE}, resp_data);
            rd({b, 15'h0002, i[0]});
            check_data("block code", {14'h0000, b[1], b[0]}, resp_data);
        end
        check_data("mode", 16'h0001, {14'h0000, cur_mode});
        busy = 1'b1;
        run(3'h0, 21'h00000, 8'h70);
        rd(21'($urandom));
        check_data("status busy", exp_sr(1'b1, 1'b0), resp_data);
        #1 err_set = 1'b1;
        #1 err_set = 1'b0;
        run(3'h0, 21'h00000, 8'h50);
        busy = 1'b0;
        rd(21'($urandom));
        check_data("clear while busy", exp_sr(1'b0, 1'b1), resp_data);
        rd(21'($urandom));
        check_data("sticky", exp_sr(1'b0, 1'b1), resp_data);
        run(3'h0, 21'h00000, 8'h50);
        rd(21'($urandom));
        check_data("cleared", exp_sr(1'b0, 1'b0), resp_data);
        run(3'h0, 21'h00000, 8'hE8);
        rd(21'($urandom));
        check_data("extended", {8'h00, EXT_SR}, resp_data);
        run(3'h0, 21'h00000, 8'h98);
        for (i = 16'h0B; i <= 16'h1B; i++) begin
            rd(21'(i));
            check_data("query", {8'h00, exp_q(i)}, resp_data);
        end
        byte_mode = 1'b1;
        for (i = 16'h20; i <= 16'h2D; i++) begin
            // byte addresses 20H-2DH: two consecutive bytes share one word offset
            rd(21'(i / 2));
            check_data("query byte", {8'h00, exp_q(i / 2)}, resp_data);
        end
        byte_mode = 1'b0;
        for (i = 0; i < 5; i++) begin
            b = 5'($urandom);
            busy = (i == 4);
            run(3'h2, {b, 16'h0000}, 8'h00);
            check_flag("block ok", i != 4, resp_ok);
            if (i != 4) check_data("block status", {14'h0000, b[1], b[0]}, resp_data);
        end
        busy = 1'b0;
        run(3'h0, 21'h00000, 8'hFF);
        a = 21'($urandom);
        rd(a);
        check_data("array again", a[15:0] ^ 16'h5A5A, resp_data);
        check_data("mode array", 16'h0000, {14'h0000, cur_mode});
        report_and_stop;
    end
endmodule
`default_nettype wire
